// [rtl/fsbb_consts.vh]
// Purpose: Shared constants of the fieldbus serial buffer bridge
// Assumes: 200 MHz clock, eight data bytes per fieldbus cycle
// Notes: Status bit positions other than new-set are local choices
`ifndef FSBB_CONSTS_VH
`define FSBB_CONSTS_VH

// Fieldbus cycle image
`define FSBB_NBYTES 8
`define FSBB_NBYTES_L 4'h8
`define FSBB_LEN_W 4
`define FSBB_IDX_W 3
`define FSBB_DATA_W 64
`define FSBB_BYTE_W 8
`define FSBB_BYTE_PAD 3'h0

// Store geometry, 1 kByte
`define FSBB_STORE_DEPTH 1024
`define FSBB_STORE_AW 10
`define FSBB_STORE_FULL 11'h400

// Timing
`define FSBB_CLK_KHZ 200000
`define FSBB_GAP_MS 20
`define FSBB_HOLD_MS 20
`define FSBB_CYC_W 23
// 20 ms at 200 MHz
`define FSBB_GAP_CYC 23'd4000000
`define FSBB_HOLD_CYC 23'd4000000

// Control byte 0 / buffer handshake control byte bits
`define FSBB_C0_CMD 0
`define FSBB_C0_NEWSET 7
`define FSBB_C1_RACK 0
`define FSBB_C1_SEND 2
`define FSBB_C1_COPY 3

// Status byte bits
`define FSBB_ST_BLKRD 1
`define FSBB_ST_WAIT 2
`define FSBB_ST_OVF 3
`define FSBB_ST_NEWSET 7

// Data values
`define FSBB_RST_PAT 8'haa
`define FSBB_ZERO_BYTE 8'h00
`define FSBB_CTRL_LIMIT 8'h20

`endif

// [rtl/fsbb_store.v]
// Purpose: 1 kByte byte store, first in first out
// Assumes: Push while full is dropped, pop while empty is ignored
// Notes: Head is read straight from the array
`timescale 1ns/1ps
`include "fsbb_consts.vh"

module fsbb_store (
    input wire clock,
    input wire nrst,
    input wire clr,
    input wire push,
    input wire [7:0] push_data,
    input wire pop,
    output wire [7:0] head,
    output wire empty,
    output wire full
);
    reg [7:0] mem [0:`FSBB_STORE_DEPTH-1];
    reg [`FSBB_STORE_AW-1:0] wr_ptr_reg;
    reg [`FSBB_STORE_AW-1:0] rd_ptr_reg;
    reg [`FSBB_STORE_AW:0] count_reg;
    wire do_push;
    wire do_pop;

    assign empty = (count_reg == {(`FSBB_STORE_AW+1){1'b0}});
    assign full = (count_reg == `FSBB_STORE_FULL);
    assign do_push = push && !full;
    assign do_pop = pop && !empty;
    assign head = mem[rd_ptr_reg];

    always @(posedge clock) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= push_data;
        end
    end

    always @(posedge clock) begin
        if (!nrst || clr) begin
            wr_ptr_reg <= {`FSBB_STORE_AW{1'b0}};
            rd_ptr_reg <= {`FSBB_STORE_AW{1'b0}};
            count_reg <= {(`FSBB_STORE_AW+1){1'b0}};
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (do_pop && !do_push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// [rtl/fsbb_bridge.v]
// Purpose: Data exchange between fieldbus cycle image and serial byte stream
// Assumes: Fieldbus stack and UART logic run on the same clock
// Notes: One fieldbus cycle is marked by a one-clock fb_cycle pulse
`timescale 1ns/1ps
`include "fsbb_consts.vh"

// Overview of operation
// - Read-acknowledge change copies next stored bytes out and inverts block-read toggle.
// - Read-acknowledge change with nothing pending clears presented input data to zero.
// - Send-store toggle change sends whole transmit store in order on serial link.
// - Copy toggle change appends current output data to transmit store.
// - Outside command mode, output data without copy change goes straight out with configured length.
// - Pattern AAh on four bytes held over 20 ms clears store and flags.
// - Pass-through and buffered modes, pass-through by default.
// - Pass-through telegrams are delimited by an idle gap over 20 ms.
// - Pass-through strips control characters and ends telegram at zero byte.
// - Buffered mode holds serial data and flags data waiting.
// - Buffered mode passes framing characters along with payload.
// - Store holds 1 kByte.
// - Buffered mode works together with command mode.
// - Each read-acknowledge inversion delivers next block until data-waiting falls.
// - Input byte 1 reports count of following user-data bytes.
// - Overflow flag follows store full and holds request-to-send inactive.
// - Pass-through inverts new-set toggle with every data set delivered.
module fsbb_bridge #(
    parameter [`FSBB_CYC_W-1:0] GAP_CYC = `FSBB_GAP_CYC,
    parameter [`FSBB_CYC_W-1:0] HOLD_CYC = `FSBB_HOLD_CYC
) (
    input wire clock,
    input wire nrst,
    input wire collect_mode,
    input wire [3:0] tel_len,
    input wire fb_cycle,
    input wire [7:0] fb_ctrl0,
    input wire [7:0] fb_ctrl1,
    input wire [`FSBB_DATA_W-1:0] fb_out_data,
    output reg [7:0] fb_in_status,
    output reg [7:0] fb_in_len,
    output reg [`FSBB_DATA_W-1:0] fb_in_data,
    input wire rx_valid,
    input wire [7:0] rx_byte,
    input wire tx_ready,
    output reg tx_valid,
    output reg [7:0] tx_byte,
    output reg rts_n
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_READ = 3'h1;
    localparam [2:0] ST_APPEND = 3'h2;
    localparam [2:0] ST_DIRECT = 3'h3;
    localparam [2:0] ST_SEND = 3'h4;

    function [7:0] sel_byte;
        input [`FSBB_DATA_W-1:0] d;
        input [`FSBB_IDX_W-1:0] i;
        begin
            sel_byte = d[{i, `FSBB_BYTE_PAD} +: `FSBB_BYTE_W];
        end
    endfunction

    reg [2:0] state_reg;
    reg [`FSBB_LEN_W-1:0] idx_reg;
    reg [`FSBB_DATA_W-1:0] snap_reg;
    reg [`FSBB_DATA_W-1:0] rd_buf_reg;
    reg rack_ref_reg, send_ref_reg, copy_ref_reg, newset_ref_reg;
    reg [`FSBB_DATA_W-1:0] data_ref_reg;
    reg pend_ack_reg, pend_copy_reg, pend_dir_reg, pend_send_reg;
    reg [`FSBB_CYC_W-1:0] hold_cnt_reg;
    reg block_read_toggle_reg, new_set_toggle_reg, store_overflow_flag_reg;
    reg [`FSBB_CYC_W-1:0] gap_cnt_reg;
    reg pt_busy_reg, pt_stop_reg;
    reg [`FSBB_LEN_W-1:0] pt_cnt_reg;
    reg [`FSBB_DATA_W-1:0] pt_buf_reg;

    wire pat_now = (fb_ctrl0 == `FSBB_RST_PAT) && (fb_ctrl1 == `FSBB_RST_PAT) &&
        (sel_byte(fb_out_data, 3'h0) == `FSBB_RST_PAT) &&
        (sel_byte(fb_out_data, 3'h1) == `FSBB_RST_PAT);
    wire wipe = pat_now && (hold_cnt_reg == HOLD_CYC);
    wire ev_ok = fb_cycle && !pat_now;
    // Toggle detection against previous cycle
    wire rack_chg = ev_ok && collect_mode && (fb_ctrl1[`FSBB_C1_RACK] != rack_ref_reg);
    wire copy_chg = ev_ok && collect_mode && (fb_ctrl1[`FSBB_C1_COPY] != copy_ref_reg);
    wire send_chg = ev_ok && collect_mode && (fb_ctrl1[`FSBB_C1_SEND] != send_ref_reg);
    // Direct send on new output data, suppressed in command mode
    wire dir_chg = ev_ok && !copy_chg && !fb_ctrl0[`FSBB_C0_CMD] &&
        ((fb_out_data != data_ref_reg) || (fb_ctrl0[`FSBB_C0_NEWSET] != newset_ref_reg));

    wire is_idle = (state_reg == ST_IDLE);
    wire go_ack = is_idle && pend_ack_reg;
    wire go_copy = is_idle && !pend_ack_reg && pend_copy_reg;
    wire go_dir = is_idle && !pend_ack_reg && !pend_copy_reg && pend_dir_reg;
    wire go_send = is_idle && !pend_ack_reg && !pend_copy_reg && !pend_dir_reg && pend_send_reg;
    wire [`FSBB_LEN_W-1:0] tel_lim = ((tel_len == {`FSBB_LEN_W{1'b0}}) ||
        (tel_len > `FSBB_NBYTES_L)) ? `FSBB_NBYTES_L : tel_len;
    wire tx_adv = !tx_valid || tx_ready;

    wire rxs_empty, rxs_full, txs_empty, txs_full;
    wire [7:0] rxs_head, txs_head;
    wire rxs_push = rx_valid && collect_mode;
    wire rxs_pop = (state_reg == ST_READ) && (idx_reg < `FSBB_NBYTES_L) && !rxs_empty;
    wire txs_push = (state_reg == ST_APPEND) && (idx_reg < tel_lim);
    wire txs_pop = (state_reg == ST_SEND) && tx_adv && !txs_empty;
    wire pt_present = pt_busy_reg && !rx_valid && (gap_cnt_reg == GAP_CYC) &&
        (pt_cnt_reg != {`FSBB_LEN_W{1'b0}});

    // Receive store and transmit store, 1 kByte each
    fsbb_store u_rx_store (
        .clock(clock),
        .nrst(nrst),
        .clr(wipe),
        .push(rxs_push),
        .push_data(rx_byte),
        .pop(rxs_pop),
        .head(rxs_head),
        .empty(rxs_empty),
        .full(rxs_full)
    );

    fsbb_store u_tx_store (
        .clock(clock),
        .nrst(nrst),
        .clr(wipe),
        .push(txs_push),
        .push_data(sel_byte(snap_reg, idx_reg[`FSBB_IDX_W-1:0])),
        .pop(txs_pop),
        .head(txs_head),
        .empty(txs_empty),
        .full(txs_full)
    );

    // Reference values, pending events, reset pattern timer
    always @(posedge clock) begin
        if (!nrst || wipe) begin
            rack_ref_reg <= 1'b0;
            send_ref_reg <= 1'b0;
            copy_ref_reg <= 1'b0;
            newset_ref_reg <= 1'b0;
            data_ref_reg <= {`FSBB_DATA_W{1'b0}};
            pend_ack_reg <= 1'b0;
            pend_copy_reg <= 1'b0;
            pend_dir_reg <= 1'b0;
            pend_send_reg <= 1'b0;
            snap_reg <= {`FSBB_DATA_W{1'b0}};
        end else begin
            if (fb_cycle) begin
                rack_ref_reg <= fb_ctrl1[`FSBB_C1_RACK];
                send_ref_reg <= fb_ctrl1[`FSBB_C1_SEND];
                copy_ref_reg <= fb_ctrl1[`FSBB_C1_COPY];
                newset_ref_reg <= fb_ctrl0[`FSBB_C0_NEWSET];
                data_ref_reg <= fb_out_data;
            end
            if (copy_chg || dir_chg) begin
                snap_reg <= fb_out_data;
            end
            // New event wins over the take in the same clock
            pend_ack_reg <= (pend_ack_reg && !go_ack) || rack_chg;
            pend_copy_reg <= (pend_copy_reg && !go_copy) || copy_chg;
            pend_dir_reg <= (pend_dir_reg && !go_dir) || dir_chg;
            pend_send_reg <= (pend_send_reg && !go_send) || send_chg;
        end
    end

    always @(posedge clock) begin
        if (!nrst || !pat_now) begin
            hold_cnt_reg <= {`FSBB_CYC_W{1'b0}};
        end else if (hold_cnt_reg != HOLD_CYC + 1'b1) begin
            hold_cnt_reg <= hold_cnt_reg + 1'b1;
        end
    end

    // Pass-through telegram assembly
    always @(posedge clock) begin
        if (!nrst || wipe || collect_mode) begin
            gap_cnt_reg <= {`FSBB_CYC_W{1'b0}};
            pt_busy_reg <= 1'b0;
            pt_stop_reg <= 1'b0;
            pt_cnt_reg <= {`FSBB_LEN_W{1'b0}};
            pt_buf_reg <= {`FSBB_DATA_W{1'b0}};
        end else if (rx_valid) begin
            gap_cnt_reg <= {`FSBB_CYC_W{1'b0}};
            pt_busy_reg <= 1'b1;
            if (!pt_stop_reg) begin
                if (rx_byte == `FSBB_ZERO_BYTE) begin
                    pt_stop_reg <= 1'b1;
                end else if (rx_byte >= `FSBB_CTRL_LIMIT && pt_cnt_reg < `FSBB_NBYTES_L) begin
                    pt_buf_reg[{pt_cnt_reg[`FSBB_IDX_W-1:0], `FSBB_BYTE_PAD} +:
                        `FSBB_BYTE_W] <= rx_byte;
                    pt_cnt_reg <= pt_cnt_reg + 1'b1;
                end
            end
        end else if (pt_busy_reg) begin
            if (gap_cnt_reg == GAP_CYC) begin
                // Gap over: telegram closed, buffer handed over this clock
                pt_busy_reg <= 1'b0;
                pt_stop_reg <= 1'b0;
                pt_cnt_reg <= {`FSBB_LEN_W{1'b0}};
                pt_buf_reg <= {`FSBB_DATA_W{1'b0}};
                gap_cnt_reg <= {`FSBB_CYC_W{1'b0}};
            end else begin
                gap_cnt_reg <= gap_cnt_reg + 1'b1;
            end
        end
    end

    // Main sequencer, input image and serial transmitter
    always @(posedge clock) begin
        if (!nrst || wipe) begin
            state_reg <= ST_IDLE;
            idx_reg <= {`FSBB_LEN_W{1'b0}};
            rd_buf_reg <= {`FSBB_DATA_W{1'b0}};
            block_read_toggle_reg <= 1'b0;
            new_set_toggle_reg <= 1'b0;
            fb_in_data <= {`FSBB_DATA_W{1'b0}};
            fb_in_len <= 8'h00;
            tx_valid <= 1'b0;
            tx_byte <= 8'h00;
        end else begin
            if (tx_valid && tx_ready) begin
                tx_valid <= 1'b0;
            end
            if (pt_present) begin
                fb_in_data <= pt_buf_reg;
                fb_in_len <= {{(8-`FSBB_LEN_W){1'b0}}, pt_cnt_reg};
                new_set_toggle_reg <= !new_set_toggle_reg;
            end
            case (state_reg)
                ST_IDLE: begin
                    idx_reg <= {`FSBB_LEN_W{1'b0}};
                    rd_buf_reg <= {`FSBB_DATA_W{1'b0}};
                    if (go_ack) begin
                        if (rxs_empty) begin
                            fb_in_data <= {`FSBB_DATA_W{1'b0}};
                            fb_in_len <= 8'h00;
                        end else begin
                            state_reg <= ST_READ;
                        end
                    end else if (go_copy) begin
                        state_reg <= ST_APPEND;
                    end else if (go_dir) begin
                        state_reg <= ST_DIRECT;
                    end else if (go_send) begin
                        state_reg <= ST_SEND;
                    end
                end
                ST_READ: begin
                    if (rxs_pop) begin
                        rd_buf_reg[{idx_reg[`FSBB_IDX_W-1:0], `FSBB_BYTE_PAD} +:
                            `FSBB_BYTE_W] <= rxs_head;
                        idx_reg <= idx_reg + 1'b1;
                    end else begin
                        fb_in_data <= rd_buf_reg;
                        fb_in_len <= {{(8-`FSBB_LEN_W){1'b0}}, idx_reg};
                        block_read_toggle_reg <= !block_read_toggle_reg;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_APPEND: begin
                    if (idx_reg < tel_lim) begin
                        idx_reg <= idx_reg + 1'b1;
                    end else begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_DIRECT: begin
                    if (tx_adv) begin
                        if (idx_reg < tel_lim) begin
                            tx_byte <= sel_byte(snap_reg, idx_reg[`FSBB_IDX_W-1:0]);
                            tx_valid <= 1'b1;
                            idx_reg <= idx_reg + 1'b1;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_SEND: begin
                    if (tx_adv) begin
                        if (!txs_empty) begin
                            tx_byte <= txs_head;
                            tx_valid <= 1'b1;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Status byte and flow control
    always @(posedge clock) begin
        if (!nrst || wipe) begin
            store_overflow_flag_reg <= 1'b0;
            rts_n <= 1'b0;
            fb_in_status <= 8'h00;
        end else begin
            store_overflow_flag_reg <= rxs_full || txs_full;
            rts_n <= rxs_full || txs_full;
            fb_in_status <= 8'h00;
            fb_in_status[`FSBB_ST_BLKRD] <= block_read_toggle_reg;
            fb_in_status[`FSBB_ST_WAIT] <= !rxs_empty;
            fb_in_status[`FSBB_ST_OVF] <= store_overflow_flag_reg;
            fb_in_status[`FSBB_ST_NEWSET] <= new_set_toggle_reg;
        end
    end
endmodule

// [verification/fsbb_bridge_monitor.sv]
// Purpose: Port checker for the fieldbus serial buffer bridge
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound to every fsbb_bridge instance
`timescale 1ns/1ps
module fsbb_bridge_monitor (
    input wire clock,
    input wire nrst,
    input wire collect_mode,
    input wire tx_ready,
    input wire [7:0] fb_in_status,
    input wire [7:0] fb_in_len,
    input wire [63:0] fb_in_data,
    input wire tx_valid,
    input wire [7:0] tx_byte,
    input wire rts_n
);
    // Bytes covered by the reported length
    wire [63:0] keep = (fb_in_len >= 8'h08) ? {64{1'b1}} :
        ((64'h1 << {fb_in_len, 3'h0}) - 64'h1);

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_reset_clear: assert property ($rose(nrst) |-> fb_in_status == 8'h00 &&
        fb_in_len == 8'h00 && fb_in_data == 64'h0 && !tx_valid && !rts_n)
        else $error("outputs not cleared after reset");
    a_tx_byte_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("transmit byte dropped or changed before taken");
    a_len_range: assert property (fb_in_len <= 8'h08)
        else $error("length count out of range");
    a_zero_fill: assert property ((fb_in_data & ~keep) == 64'h0)
        else $error("input bytes past length not zero");
    a_new_set_flip: assert property (!collect_mode && $changed(fb_in_data) &&
        fb_in_len != 8'h00 |=> $changed(fb_in_status[7]))
        else $error("new set toggle did not flip");
    a_block_flip: assert property (collect_mode && $changed(fb_in_data) &&
        fb_in_len != 8'h00 |=> $changed(fb_in_status[1]))
        else $error("block read toggle did not flip");
    a_ovf_rts: assert property ($rose(fb_in_status[3]) |-> ##[0:2] rts_n)
        else $error("request to send active while overflow");
    a_rts_release: assert property ($fell(rts_n) |-> ##[0:2] !fb_in_status[3])
        else $error("overflow flag stuck after space freed");
endmodule

bind fsbb_bridge fsbb_bridge_monitor mon (.clock(clock), .nrst(nrst),
    .collect_mode(collect_mode), .tx_ready(tx_ready), .fb_in_status(fb_in_status),
    .fb_in_len(fb_in_len), .fb_in_data(fb_in_data), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .rts_n(rts_n));

// [verification/fsbb_serial_dev.sv]
// Purpose: Serial end device model on the link side of the bridge
// Assumes: Byte-level link, one byte per rx_valid pulse
// Notes: slow stalls the transmit side every other clock
`timescale 1ns/1ps
module fsbb_serial_dev (
    input wire clock,
    input wire slow,
    input wire tx_valid,
    input wire [7:0] tx_byte,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_byte
);
    logic [7:0] got[$];
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
    end
    // Bytes kept in link order
    always @(posedge clock)
        if (tx_valid && tx_ready)
            got.push_back(tx_byte);
    always @(negedge clock)
        tx_ready <= slow ? ~tx_ready : 1'b1;
    // Inverse after the pulse so no stale byte is seen
    task send(input [7:0] b);
        @(negedge clock);
        rx_valid = 1'b1;
        rx_byte = b;
        @(negedge clock);
        rx_valid = 1'b0;
        rx_byte = ~b;
    endtask
endmodule

// [verification/fsbb_bridge_tb.sv]
// Purpose: Self-checking bench for the fieldbus serial buffer bridge
// Assumes: Short gap and hold counts, inputs driven on falling edge
// Notes: Master side driven here, serial side by fsbb_serial_dev
`timescale 1ns/1ps
module fsbb_bridge_tb;
    logic clock, nrst, mode, fbc, slow, rxv, txr, txv, rts_n;
    logic [3:0] tlen;
    logic [7:0] c0, c1, st, ln, rxb, txb;
    logic [63:0] od, id;
    int n_mismatch, compares, k;

    fsbb_bridge #(.GAP_CYC(23'd20), .HOLD_CYC(23'd30)) dut (.clock(clock), .nrst(nrst),
        .collect_mode(mode), .tel_len(tlen), .fb_cycle(fbc), .fb_ctrl0(c0), .fb_ctrl1(c1),
        .fb_out_data(od), .fb_in_status(st), .fb_in_len(ln), .fb_in_data(id),
        .rx_valid(rxv), .rx_byte(rxb), .tx_ready(txr), .tx_valid(txv), .tx_byte(txb),
        .rts_n(rts_n));
    fsbb_serial_dev dev (.clock(clock), .slow(slow), .tx_valid(txv), .tx_byte(txb),
        .tx_ready(txr), .rx_valid(rxv), .rx_byte(rxb));

    task chk(input logic [63:0] g, input logic [63:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task end_sim;
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task img(input [7:0] l, input [63:0] d);
        chk(ln, l);
        chk(id, d);
    endtask
    task rst;
        nrst = 1'b0;
        c0 = 8'h00;
        c1 = 8'h00;
        od = 64'h0;
        fbc = 1'b0;
        repeat (16) @(negedge clock);
        nrst = 1'b1;
        dev.got.delete();
    endtask
    // One fieldbus cycle, then a quiet fieldbus period
    task cyc(input [7:0] a, input [7:0] b, input [63:0] d);
        @(negedge clock);
        c0 = a;
        c1 = b;
        od = d;
        fbc = 1'b1;
        @(negedge clock);
        fbc = 1'b0;
        repeat (30) @(negedge clock);
    endtask
    task snd(input [63:0] v, input int n);
        for (int i = 0; i < n; i++)
            dev.send(v[8*i +: 8]);
    endtask
    task wait_tx(input int n);
        for (k = 0; k < 400 && dev.got.size() < n; k++)
            @(negedge clock);
        if (k == 400) begin
            n_mismatch++;
            end_sim;
        end
    endtask

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    initial begin
        mode = 1'b0;
        slow = 1'b0;
        tlen = 4'h0;
        rst;
        chk({40'h0, st, ln, 6'h0, rts_n, txv}, 64'h0);
        chk(id, 64'h0);
        snd(64'h42_0d_41, 3);
        repeat (30) @(negedge clock);
        img(8'h02, 64'h4241);
        chk(st[7], 1'b1);
        snd(64'h3736353433323130, 8);
        snd(64'h3938, 2);
        repeat (30) @(negedge clock);
        img(8'h08, 64'h3736353433323130);
        chk(st[7], 1'b0);
        snd(64'h44_00_43, 3);
        repeat (30) @(negedge clock);
        img(8'h01, 64'h43);
        tlen = 4'h3;
        slow = 1'b1;
        cyc(8'h00, 8'h00, 64'h6665646362_61);
        wait_tx(3);
        chk({dev.got[0], dev.got[1], dev.got[2]}, 24'h616263);
        cyc(8'h01, 8'h00, 64'h71);
        chk(dev.got.size(), 3);
        mode = 1'b1;
        tlen = 4'h2;
        rst;
        cyc(8'h00, 8'h08, 64'h7271);
        cyc(8'h00, 8'h00, 64'h7473);
        chk(dev.got.size(), 0);
        cyc(8'h00, 8'h04, 64'h7473);
        wait_tx(4);
        chk({dev.got[0], dev.got[1], dev.got[2], dev.got[3]}, 32'h71727374);
        snd(64'h4746454443424102, 8);
        snd(64'h0d48, 2);
        repeat (4) @(negedge clock);
        chk({ln, 5'h0, st[2:0]}, 16'h0004);
        cyc(8'h00, 8'h05, 64'h7473);
        img(8'h08, 64'h4746454443424102);
        chk(st[2:1], 2'b11);
        cyc(8'h00, 8'h04, 64'h7473);
        img(8'h02, 64'h0d48);
        chk(st[2:1], 2'b00);
        cyc(8'h00, 8'h05, 64'h7473);
        img(8'h00, 64'h0);
        for (int i = 0; i < 1023; i++)
            dev.send(i[7:0]);
        repeat (4) @(negedge clock);
        chk({rts_n, st[3]}, 2'b00);
        dev.send(8'hff);
        repeat (4) @(negedge clock);
        chk({rts_n, st[3]}, 2'b11);
        cyc(8'h00, 8'h04, 64'h7473);
        chk({rts_n, st[3]}, 2'b00);
        img(8'h08, 64'h0706050403020100);
        cyc(8'haa, 8'haa, 64'haaaa);
        repeat (10) @(negedge clock);
        chk({st, ln}, 16'h0);
        chk(id, 64'h0);
        cyc(8'h00, 8'h00, 64'haaaa);
        cyc(8'h00, 8'h01, 64'haaaa);
        img(8'h00, 64'h0);
        chk(st[2], 1'b0);
        end_sim;
    end
endmodule
